// ===== src/acs_sequencer.sv
// Conversion sequencer of a 10-bit, eight-channel successive-approximation converter.
// Assumes the comparator presents a settled code on convCode when the conversion time ends.
`timescale 1ns/10ps
module acs_sequencer
   import acs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   // Power state
   input wire logic stopMode,
   // Analog front end
   input wire logic [9:0] convCode,
   output logic [2:0] channelSel,
   output logic analogInputEnable,
   output logic refConnect,
   output logic sampleStart,
   output logic convActive,
   // Interrupts
   output logic convDoneIrq,
   output logic convDonePulse
);

   acs_state_e state_q, state_d;
   logic [7:0] ctrlOne_q, ctrlOne_d;
   logic [7:0] ctrlTwo_q, ctrlTwo_d;
   logic [9:0] result_q, result_d;
   logic [2:0] chan_q, chan_d;
   logic mask_q, mask_d;
   logic [7:0] rdata_q, rdata_d;
   logic ainEn_q, ainEn_d;
   logic ref_q, ref_d;
   logic sample_q, sample_d;
   logic pulse_q, pulse_d;
   logic irq_q, irq_d;

   logic wrCtrlOne, wrCtrlTwo, wrStat, wrMask;
   logic rdResult;
   acs_mode_e wrMode, curMode;
   logic swStart, disableWr, finish, autoRestart, abort, timerLoad;
   logic timerExpire, doneFlag, statFlag, doneClr;
   logic [CNT_W-1:0] loadCount;

   always_comb begin
      wrCtrlOne = regWrite && (regAddr == ADDR_CTRL_ONE);
      wrCtrlTwo = regWrite && (regAddr == ADDR_CTRL_TWO);
      wrStat = regWrite && (regAddr == ADDR_IRQ_STAT);
      wrMask = regWrite && (regAddr == ADDR_IRQ_MASK);
      rdResult = regRead && ((regAddr == ADDR_RES_HIGH) || (regAddr == ADDR_RES_LOW));
      wrMode = acs_mode_e'(regWdata[MODE_HI:MODE_LO]);
      curMode = acs_mode_e'(ctrlOne_q[MODE_HI:MODE_LO]);
      // Start ignored while busy, in stop, or with disable/reserved mode
      swStart = wrCtrlOne && regWdata[START_BIT] && !stopMode && (state_q == ST_IDLE)
         && ((wrMode == MODE_SINGLE) || (wrMode == MODE_REPEAT));
      disableWr = wrCtrlOne && (wrMode == MODE_DISABLE);
      abort = stopMode || disableWr;
      finish = timerExpire && (state_q == ST_CONV) && !abort;
      autoRestart = finish && (curMode == MODE_REPEAT);
      timerLoad = swStart || autoRestart;
      loadCount = CONV_CYCLES[ctrlTwo_q[TIME_HI:TIME_LO]];
      doneClr = rdResult || swStart || stopMode;
   end

   acs_conv_timer u_timer (
      .clk(clk),
      .rstn(rstn),
      .load(timerLoad),
      .abort(abort),
      .loadCount(loadCount),
      .expire(timerExpire)
   );

   acs_sticky_flag u_done (
      .clk(clk),
      .rstn(rstn),
      .set(finish),
      .clr(doneClr),
      .flag(doneFlag)
   );

   acs_sticky_flag u_stat (
      .clk(clk),
      .rstn(rstn),
      .set(finish),
      .clr(wrStat && regWdata[IRQ_DONE_BIT]),
      .flag(statFlag)
   );

   // Sequencer state and control registers
   always_comb begin
      state_d = state_q;
      ctrlOne_d = ctrlOne_q;
      ctrlTwo_d = ctrlTwo_q;
      chan_d = chan_q;
      result_d = result_q;
      if (stopMode) begin
         state_d = ST_IDLE;
         ctrlOne_d = CTRL_ONE_RST;
         ctrlTwo_d = CTRL_TWO_RST;
         result_d = RESULT_RST;
      end else begin
         if (wrCtrlOne) begin
            // Start bit is never stored, so it always reads as zero
            ctrlOne_d = regWdata & ~START_MASK;
         end
         if (wrCtrlTwo) begin
            ctrlTwo_d = regWdata;
         end
         if (disableWr) begin
            state_d = ST_IDLE;
         end else if (swStart) begin
            state_d = ST_CONV;
            chan_d = regWdata[CHAN_HI:CHAN_LO];
         end else if (finish && !autoRestart) begin
            state_d = ST_IDLE;
         end
         if (finish) begin
            result_d = convCode;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         ctrlOne_q <= CTRL_ONE_RST;
         ctrlTwo_q <= CTRL_TWO_RST;
         chan_q <= 3'h0;
         result_q <= RESULT_RST;
      end else begin
         state_q <= state_d;
         ctrlOne_q <= ctrlOne_d;
         ctrlTwo_q <= ctrlTwo_d;
         chan_q <= chan_d;
         result_q <= result_d;
      end
   end

   // Register read, outputs and interrupt
   always_comb begin
      mask_d = wrMask ? regWdata[IRQ_DONE_BIT] : mask_q;
      rdata_d = 8'h00;
      if (regRead) begin
         case (regAddr)
            ADDR_CTRL_ONE: rdata_d = ctrlOne_q;
            ADDR_CTRL_TWO: rdata_d = ctrlTwo_q;
            ADDR_RES_HIGH: rdata_d = result_q[9:2];
            ADDR_RES_LOW: rdata_d = {result_q[1:0], doneFlag, 5'h00};
            ADDR_IRQ_STAT: rdata_d = {7'h00, statFlag};
            ADDR_IRQ_MASK: rdata_d = {7'h00, mask_q};
            default: rdata_d = 8'h00;
         endcase
      end
      ainEn_d = !ctrlOne_d[AIN_DIS_BIT];
      ref_d = ctrlTwo_d[REF_BIT] && !stopMode;
      sample_d = timerLoad;
      pulse_d = finish;
      // One cycle behind the status bit, so a clear drops it a cycle later
      irq_d = statFlag && mask_q;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         mask_q <= 1'b0;
         rdata_q <= 8'h00;
         ainEn_q <= 1'b0;
         ref_q <= 1'b0;
         sample_q <= 1'b0;
         pulse_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         mask_q <= mask_d;
         rdata_q <= rdata_d;
         ainEn_q <= ainEn_d;
         ref_q <= ref_d;
         sample_q <= sample_d;
         pulse_q <= pulse_d;
         irq_q <= irq_d;
      end
   end

   assign regRdata = rdata_q;
   assign channelSel = chan_q;
   assign analogInputEnable = ainEn_q;
   assign refConnect = ref_q;
   assign sampleStart = sample_q;
   assign convActive = (state_q == ST_CONV);
   assign convDoneIrq = irq_q;
   assign convDonePulse = pulse_q;

   // Checking helpers
   logic [CNT_W-1:0] elapsed_q, target_q;
   logic [7:0] resHigh;
   logic [2:0] wrChan;
   assign resHigh = result_q[9:2];
   assign wrChan = regWdata[CHAN_HI:CHAN_LO];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         elapsed_q <= '0;
         target_q <= '0;
      end else begin
         elapsed_q <= sample_q ? 12'h001 : elapsed_q + 12'h001;
         if (timerLoad) begin
            target_q <= loadCount;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   chk_single_start: assert property (
      swStart |=> convActive && sampleStart)
      else $error("start did not begin a conversion");
   chk_done_store: assert property (
      finish |=> doneFlag && convDonePulse && result_q == $past(convCode) && statFlag)
      else $error("completion did not store and flag");
   chk_start_reads_zero: assert property (
      regRead && regAddr == ADDR_CTRL_ONE |=> !regRdata[START_BIT])
      else $error("start bit read back as one");
   chk_repeat_relaunch: assert property (
      finish && curMode == MODE_REPEAT |=> convActive && sampleStart)
      else $error("repeat mode did not relaunch");
   chk_disable_stop: assert property (
      disableWr && convActive |=> !convActive && result_q == $past(result_q) ##1 !convDonePulse)
      else $error("disable did not stop cleanly");
   chk_read_clears: assert property (
      rdResult && !finish |=> !doneFlag)
      else $error("result read left done set");
   chk_restart_keeps: assert property (
      swStart |=> !doneFlag && result_q == $past(result_q))
      else $error("new start mishandled done or result");
   chk_conv_length: assert property (
      finish |-> elapsed_q == target_q)
      else $error("conversion length wrong");
   chk_stop_reset: assert property (
      stopMode |=> ctrlOne_q == CTRL_ONE_RST && ctrlTwo_q == CTRL_TWO_RST && !convActive)
      else $error("stop did not reset the sequencer");
   chk_no_resume: assert property (
      $fell(stopMode) && !swStart |-> !convActive [*2])
      else $error("conversion resumed after stop");
   chk_ref_off: assert property (
      stopMode |=> !refConnect)
      else $error("reference connected in stop");
   chk_high_split: assert property (
      regRead && regAddr == ADDR_RES_HIGH |=> regRdata == $past(resHigh))
      else $error("high result byte wrong");
   chk_channel_pick: assert property (
      swStart |=> channelSel == $past(wrChan))
      else $error("channel not taken from start write");
   chk_one_request: assert property (
      finish |=> convDonePulse ##1 !convDonePulse)
      else $error("completion request not a single pulse");

   cov_single_done: cover property (swStart ##[1:1000] finish && curMode == MODE_SINGLE);
   cov_repeat_twice: cover property (autoRestart ##[1:1000] autoRestart);
   cov_disable_abort: cover property (convActive && disableWr);
   cov_stop_abort: cover property (convActive && stopMode);

endmodule

// ===== src/acs_pkg.sv
// Constants, field layout and enumerations of the conversion sequencer.
// Shared by the sequencer top, its conversion timer and the testbench.
package acs_pkg;

   // Register indices on the 3-bit register port
   localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
   localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
   localparam logic [2:0] ADDR_RES_HIGH = 3'h2;
   localparam logic [2:0] ADDR_RES_LOW = 3'h3;
   localparam logic [2:0] ADDR_IRQ_STAT = 3'h4;
   localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;

   // conv_ctrl_one fields
   localparam int START_BIT = 7;
   localparam int MODE_HI = 6;
   localparam int MODE_LO = 5;
   localparam int AIN_DIS_BIT = 4;
   localparam int CHAN_HI = 2;
   localparam int CHAN_LO = 0;

   // conv_ctrl_two fields
   localparam int REF_BIT = 4;
   localparam int TIME_HI = 3;
   localparam int TIME_LO = 1;

   // result_low_reg and interrupt register fields
   localparam int DONE_BIT = 5;
   localparam int IRQ_DONE_BIT = 0;

   // Reset values; inputs start disconnected from the converter
   localparam logic [7:0] CTRL_ONE_RST = 8'h10;
   localparam logic [7:0] CTRL_TWO_RST = 8'h00;
   localparam logic [7:0] START_MASK = 8'h80;
   localparam logic [9:0] RESULT_RST = 10'h000;

   localparam int CNT_W = 12;

   // Conversion length in system clock cycles per conversion-time code
   localparam logic [CNT_W-1:0] CONV_CYCLES [8] = '{
      12'h027, 12'h04e, 12'h09c, 12'h138, 12'h270, 12'h4e0, 12'h9c0, 12'hea0
   };

   typedef enum logic [1:0] {
      MODE_DISABLE = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_RSVD = 2'b10,
      MODE_REPEAT = 2'b11
   } acs_mode_e;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_CONV = 1'b1
   } acs_state_e;

endpackage

// ===== src/acs_conv_timer.sv
// Down counter that times one conversion.
// Assumes load and abort are one-cycle pulses from the sequencer.
`timescale 1ns/10ps
module acs_conv_timer
   import acs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Control
   input wire logic load,
   input wire logic abort,
   input wire logic [CNT_W-1:0] loadCount,
   // Status
   output logic expire
);

   logic [CNT_W-1:0] count_q, count_d;
   logic expire_q, expire_d;

   always_comb begin
      count_d = count_q;
      expire_d = 1'b0;
      if (abort) begin
         count_d = '0;
      end else if (load) begin
         count_d = loadCount;
      end else if (count_q != '0) begin
         count_d = count_q - 12'h001;
         expire_d = (count_q == 12'h001);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         count_q <= '0;
         expire_q <= 1'b0;
      end else begin
         count_q <= count_d;
         expire_q <= expire_d;
      end
   end

   assign expire = expire_q;

endmodule

// ===== src/acs_sticky_flag.sv
// One sticky flag: a set in the same cycle as a clear wins.
// Assumes set and clear are single-cycle terms from the owner.
`timescale 1ns/10ps
module acs_sticky_flag (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Control
   input wire logic set,
   input wire logic clr,
   // State
   output logic flag
);

   logic flag_q, flag_d;

   always_comb begin
      flag_d = set | (flag_q & ~clr);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag = flag_q;

endmodule

// ===== test/acs_front_model.sv
// Analog multiplexer and comparator model facing the sequencer.
// Assumes the bench holds codeBase steady during a conversion.
`timescale 1ns/10ps
module acs_front_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Sequencer side
   input wire logic [2:0] channelSel,
   input wire logic sampleStart,
   input wire logic convActive,
   // Bench side
   input wire logic [9:0] codeBase,
   // Comparator result
   output logic [9:0] convCode
);
   logic [2:0] chanQ;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         chanQ <= 3'h0;
         convCode <= 10'h155;
      end else begin
         if (sampleStart) begin
            chanQ <= channelSel;
         end
         // Toggles outside conversions so a stale code never looks valid
         if (convActive) begin
            convCode <= codeBase ^ {chanQ, 7'h00};
         end else begin
            convCode <= ~convCode;
         end
      end
   end
endmodule

// ===== test/testbench.sv
// Self-checking bench for the conversion sequencer.
// Assumes the front-end model answers every conversion.
`timescale 1ns/10ps
module testbench
   import acs_pkg::*;
;
   logic clk, rstn, regWrite, regRead, stopMode, analogInputEnable, refConnect;
   logic sampleStart, convActive, convDoneIrq, convDonePulse;
   logic [2:0] regAddr, channelSel;
   logic [7:0] regWdata, regRdata;
   logic [9:0] convCode, codeBase;
   int error_cnt = 0;
   int comparisons = 0;
   int pulseCnt = 0;
   logic [7:0] rstVal [8] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   acs_sequencer dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .stopMode(stopMode),
      .convCode(convCode), .channelSel(channelSel), .analogInputEnable(analogInputEnable),
      .refConnect(refConnect), .sampleStart(sampleStart), .convActive(convActive),
      .convDoneIrq(convDoneIrq), .convDonePulse(convDonePulse));
   acs_front_model front (.clk(clk), .rstn(rstn), .channelSel(channelSel),
      .sampleStart(sampleStart), .convActive(convActive), .codeBase(codeBase),
      .convCode(convCode));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (convDonePulse === 1'b1) pulseCnt <= pulseCnt + 1;
   end

   task automatic stop_test();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rdChk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      chk("regRdata", {2'b00, exp}, {2'b00, regRdata});
   endtask
   // Counts edges after the start write until the completion pulse
   task automatic waitPulse(output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (convDonePulse !== 1'b1 && k < 5000);
      if (k >= 5000) begin
         error_cnt++;
         stop_test();
      end
   endtask
   function automatic logic [9:0] expCode(input logic [2:0] ch, input logic [9:0] b);
      return b ^ {ch, 7'h00};
   endfunction

   initial begin
      int k;
      int p;
      logic [2:0] ch;
      logic [9:0] res;
      logic [9:0] old;
      rstn = 1'b0;
      regAddr = 3'h0;
      regWdata = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      stopMode = 1'b0;
      codeBase = 10'h000;
      void'($urandom(32'h9156));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      wr(3'h6, 8'hff);
      for (int i = 0; i < 8; i++) rdChk(3'(i), rstVal[i]);
      for (int t = 0; t < 8; t++) begin
         ch = 3'($urandom);
         res = 10'($urandom);
         codeBase <= res;
         res = expCode(ch, res);
         wr(ADDR_IRQ_MASK, 8'(t % 2));
         wr(ADDR_CTRL_TWO, 8'h10 | 8'(t << 1));
         p = pulseCnt;
         wr(ADDR_CTRL_ONE, 8'ha0 | 8'(ch));
         #1;
         chk("channelSel", 10'(ch), 10'(channelSel));
         chk("analogInputEnable", 10'h1, 10'(analogInputEnable));
         chk("refConnect", 10'h1, 10'(refConnect));
         waitPulse(k);
         chk("latency", 16'(CONV_CYCLES[t] + 1), 16'(k));
         @(posedge clk);
         #1;
         chk("convDoneIrq", 10'(t % 2), 10'(convDoneIrq));
         chk("pulses", 10'(p + 1), 10'(pulseCnt));
         rdChk(ADDR_CTRL_ONE, 8'h20 | 8'(ch));
         rdChk(ADDR_RES_LOW, {res[1:0], 6'h20});
         rdChk(ADDR_RES_HIGH, res[9:2]);
         rdChk(ADDR_RES_LOW, {res[1:0], 6'h00});
         rdChk(ADDR_IRQ_STAT, 8'h01);
         wr(ADDR_IRQ_STAT, 8'h01);
         rdChk(ADDR_IRQ_STAT, 8'h00);
         chk("convDoneIrq", 10'h0, 10'(convDoneIrq));
      end
      // Restart while done is set, result unread
      wr(ADDR_CTRL_TWO, 8'h00);
      wr(ADDR_CTRL_ONE, 8'ha0 | 8'(ch));
      waitPulse(k);
      old = res;
      res = 10'($urandom);
      codeBase <= res;
      res = expCode(ch, res);
      wr(ADDR_CTRL_ONE, 8'ha0 | 8'(ch));
      rdChk(ADDR_RES_LOW, {old[1:0], 6'h00});
      rdChk(ADDR_RES_HIGH, old[9:2]);
      waitPulse(k);
      rdChk(ADDR_RES_HIGH, res[9:2]);
      // Repeat mode, then disable in mid-conversion
      wr(ADDR_CTRL_ONE, 8'he0 | 8'(ch));
      waitPulse(k);
      p = pulseCnt;
      waitPulse(k);
      // Relaunch costs the same extra cycle as a software start
      chk("period", 16'(CONV_CYCLES[0] + 1), 16'(k));
      rdChk(ADDR_CTRL_ONE, 8'h60 | 8'(ch));
      waitPulse(k);
      @(posedge clk);
      #1;
      chk("pulses", 10'(p + 3), 10'(pulseCnt));
      codeBase <= ~codeBase;
      wr(ADDR_CTRL_ONE, 8'(ch));
      #1;
      chk("convActive", 10'h0, 10'(convActive));
      p = pulseCnt;
      repeat (60) @(posedge clk);
      chk("pulses", 10'(p), 10'(pulseCnt));
      rdChk(ADDR_RES_HIGH, res[9:2]);
      // Reserved mode code must not launch
      wr(ADDR_CTRL_ONE, 8'hc0 | 8'(ch));
      #1;
      chk("convActive", 10'h0, 10'(convActive));
      chk("sampleStart", 10'h0, 10'(sampleStart));
      // Stop standby during a long conversion
      wr(ADDR_CTRL_TWO, 8'h1e);
      wr(ADDR_CTRL_ONE, 8'ha0 | 8'(ch));
      repeat (20) @(posedge clk);
      stopMode <= 1'b1;
      @(posedge clk);
      #1;
      chk("convActive", 10'h0, 10'(convActive));
      chk("refConnect", 10'h0, 10'(refConnect));
      chk("analogInputEnable", 10'h0, 10'(analogInputEnable));
      wr(ADDR_CTRL_ONE, 8'ha0);
      stopMode <= 1'b0;
      rdChk(ADDR_CTRL_ONE, CTRL_ONE_RST);
      rdChk(ADDR_CTRL_TWO, CTRL_TWO_RST);
      p = pulseCnt;
      repeat (3800) @(posedge clk);
      #1;
      chk("pulses", 10'(p), 10'(pulseCnt));
      chk("convActive", 10'h0, 10'(convActive));
      stop_test();
   end
endmodule
